//--- sdcd_burst_ctr.sv
// Two-bit burst counter producing the low word address bits.
`timescale 1ns/1ps
module sdcd_burst_ctr
    import sdcd_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Control from the address stage.
    input wire logic load,
    input wire logic [BURST_W-1:0] load_bits,
    input wire logic step,
    input wire logic linear_mode,
    // Low address bits of the current beat.
    output logic [BURST_W-1:0] burst_low
);

    // =========================================================
    // State
    // =========================================================
    logic [BURST_W-1:0] base_reg;   // Low bits captured with the address.
    logic [BURST_W-1:0] beat_reg;   // Beats advanced since the load.

    // Forms the beat address in either order.
    function automatic logic [BURST_W-1:0] beat_addr(input logic [BURST_W-1:0] base,
                                                     input logic [BURST_W-1:0] beat,
                                                     input logic linear);
        if (linear) begin
            beat_addr = BURST_W'(base + beat);
        end else begin
            beat_addr = base ^ beat;
        end
    endfunction

    // A load restarts the burst; a step moves one beat and wraps modulo four.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            base_reg <= BEAT_ZERO;
            beat_reg <= BEAT_ZERO;
        end else if (load) begin
            base_reg <= load_bits;
            beat_reg <= BEAT_ZERO;
        end else if (step) begin
            beat_reg <= BURST_W'(beat_reg + BEAT_ONE);
        end
    end

    // The order only changes how beats map to addresses, so a strap change needs no reload.
    assign burst_low = beat_addr(base_reg, beat_reg, linear_mode);

endmodule

//--- sdcd_bus_model.sv
// Far-side model that resolves the shared data pins of the memory port.
`timescale 1ns/1ps
module sdcd_bus_model
    import sdcd_pkg::*;
(
    // Clock.
    input wire logic ref_clk,
    // Port side of the pins.
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    // Master side of the pins.
    input wire logic m_drive,
    input wire logic [DATA_W-1:0] m_data,
    // Resolved pin level.
    output logic [DATA_W-1:0] dq_wire
);
    // =========================================================
    // Pin resolution
    // =========================================================
    logic [DATA_W-1:0] last_reg; // Last level seen on the pins.
    // Released pins show the inverse of the last level, so the first released cycle never passes a stale word.
    assign dq_wire = dq_oe ? dq_out : (m_drive ? m_data : ~last_reg);
    // Remember the level of each cycle.
    always_ff @(posedge ref_clk) begin
        last_reg <= dq_wire;
    end
endmodule

//--- sdcd_mem_array.sv
// Storage array with byte-lane writes and a registered read port.
`timescale 1ns/1ps
module sdcd_mem_array
    import sdcd_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH
)
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Write side.
    input wire logic wr_en,
    input sdcd_wr_type wr_req,
    // Read side.
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);

    // =========================================================
    // Storage
    // =========================================================
    logic [DATA_W-1:0] mem_array [0:DEPTH-1];

    // Each enabled lane is stored on its own; other lanes keep their bytes.
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            for (int lane = 0; lane < LANES; lane++) begin
                if (wr_req.lanes[lane]) begin
                    mem_array[wr_req.addr][lane*LANE_W +: LANE_W] <=
                        wr_req.data[lane*LANE_W +: LANE_W];
                end
            end
        end
    end

    // Output register stage; a read of a word being written returns the old word.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rd_data <= DATA_RESET;
        end else if (rd_en) begin
            rd_data <= mem_array[rd_addr];
        end
    end

endmodule

//--- sdcd_pkg.sv
// Shared constants, carrier types and states of the pipelined sync memory port.
package sdcd_pkg;

    // =========================================================
    // Geometry
    // =========================================================
    localparam int ADDR_W = 17;                 // Word address width, 128K words.
    localparam int DATA_W = 32;                 // Word width.
    localparam int LANES = 4;                   // Byte lanes per word.
    localparam int LANE_W = 8;                  // Bits per lane.
    localparam int BURST_W = 2;                 // Width of the burst counter.
    localparam int MEM_DEPTH = 32'h0002_0000;   // Number of stored words.

    // =========================================================
    // Field values and reset values
    // =========================================================
    localparam logic [LANES-1:0] LANES_ALL = 4'hF;      // Every lane written.
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;     // No lane written.
    localparam logic [BURST_W-1:0] BEAT_ZERO = 2'h0;    // First beat of a burst.
    localparam logic [BURST_W-1:0] BEAT_ONE = 2'h1;     // Step of one beat.
    localparam logic STRAP_LINEAR = 1'h0;               // Strap level for linear order.
    localparam logic LINEAR_RESET = 1'h0;               // Interleaved until strap is read.
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000; // Output register at reset.
    localparam int CLK_PERIOD_PS = 5000;                // Clock period of ref_clk.

    // =========================================================
    // Carrier types
    // =========================================================
    // Synchronous control pins, all active levels as on the bus.
    typedef struct packed {
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_step_n;
        logic chip_sel_a_n;
        logic chip_sel_b;
        logic chip_sel_c_n;
        logic all_lanes_write_n;
        logic lane_write_enable_n;
        logic [LANES-1:0] lane_select_n;
    } sdcd_ctl_type;

    // One write to the array.
    typedef struct packed {
        logic [LANES-1:0] lanes;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } sdcd_wr_type;

    // Kind of the cycle held in the address stage.
    typedef enum logic [2:0] {
        ST_DESEL = 3'h1,
        ST_READ = 3'h2,
        ST_WRITE = 3'h4
    } sdcd_state_type;

endpackage

//--- sdcd_port.sv
// Top of the pipelined double-cycle-deselect synchronous memory port.
`timescale 1ns/1ps
module sdcd_port
    import sdcd_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Synchronous bus inputs.
    input wire logic [ADDR_W-1:0] addr_in,
    input sdcd_ctl_type ctl_pins,
    // Common data pins, split into input, output and enable.
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    // Asynchronous and static inputs.
    input wire logic out_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_strap,
    // Status.
    output logic selected
);

    // =========================================================
    // Decode helpers
    // =========================================================

    // True when all three chip selects sit at their active levels.
    function automatic logic chip_selected(input sdcd_ctl_type c);
        chip_selected = !c.chip_sel_a_n && c.chip_sel_b && !c.chip_sel_c_n;
    endfunction

    // Lanes to write from the sampled write controls.
    function automatic logic [LANES-1:0] write_lanes(input sdcd_ctl_type c);
        if (!c.all_lanes_write_n) begin
            write_lanes = LANES_ALL;
        end else if (!c.lane_write_enable_n) begin
            write_lanes = ~c.lane_select_n;
        end else begin
            write_lanes = LANES_NONE;
        end
    endfunction

    // =========================================================
    // Signals
    // =========================================================
    sdcd_state_type state_reg;          // Kind of the cycle in the address stage.
    sdcd_state_type state_next;         // Kind decided from the pins this cycle.
    logic [ADDR_W-1:BURST_W] addr_hi_reg; // Upper word address bits.
    logic [LANES-1:0] lanes_reg;        // Lanes of the captured write.
    logic [LANES-1:0] lanes_next;       // Lanes decoded from the pins.
    logic [DATA_W-1:0] wdata_reg;       // Write data captured from the pins.
    logic read_out_reg;                 // Output register holds fresh read data.
    logic dcd_hold_reg;                 // Drivers held one cycle after a deselect.
    logic linear_mode_reg;              // Burst order from the strap.
    logic strap_taken_reg;              // Strap has been read after reset.
    logic proc_seen;                    // Processor strobe recognised.
    logic ctrl_seen;                    // Controller strobe recognised.
    logic sel_ok;                       // Chip selects active.
    logic addr_load;                    // Load address and counter this edge.
    logic burst_step;                   // Advance the burst this edge.
    logic [BURST_W-1:0] burst_low;      // Low address bits of the beat.
    logic [ADDR_W-1:0] cur_addr;        // Address of the cycle in the address stage.
    logic wr_en;                        // Array write this edge.
    logic rd_en;                        // Array read this edge.
    sdcd_wr_type wr_req;                // Write carried to the array.
    logic [DATA_W-1:0] rd_data;         // Output register of the array.

    // =========================================================
    // Strobe and select decode
    // =========================================================

    // The processor strobe counts only with the first select low, and beats the controller.
    assign proc_seen = !ctl_pins.proc_addr_strobe_n && !ctl_pins.chip_sel_a_n;
    assign ctrl_seen = !ctl_pins.ctrl_addr_strobe_n && !proc_seen;
    assign sel_ok = chip_selected(ctl_pins);
    assign lanes_next = write_lanes(ctl_pins);

    // Next cycle kind; sleep blocks every start and step so the array stays untouched.
    always_comb begin
        state_next = state_reg;
        addr_load = 1'b0;
        burst_step = 1'b0;
        if (sleep_request) begin
            state_next = ST_DESEL;
        end else if (proc_seen) begin
            // A processor start is always a read; its write follows in a later cycle.
            if (sel_ok) begin
                addr_load = 1'b1;
                state_next = ST_READ;
            end else begin
                state_next = ST_DESEL;
            end
        end else if (ctrl_seen) begin
            // A controller start takes the write controls of the same edge.
            if (sel_ok) begin
                addr_load = 1'b1;
                state_next = (lanes_next != LANES_NONE) ? ST_WRITE : ST_READ;
            end else begin
                state_next = ST_DESEL;
            end
        end else if (state_reg != ST_DESEL) begin
            // No strobe: continue the burst, or suspend on the same address.
            burst_step = !ctl_pins.burst_step_n;
            state_next = (lanes_next != LANES_NONE) ? ST_WRITE : ST_READ;
        end else begin
            state_next = ST_DESEL;
        end
    end

    // =========================================================
    // Input registers
    // =========================================================

    // Cycle kind; every edge takes the decision made from the pins.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_reg <= ST_DESEL;
        end else begin
            state_reg <= state_next;
        end
    end

    // Upper address bits load only with a recognised strobe and selection.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            addr_hi_reg <= '0;
        end else if (addr_load) begin
            addr_hi_reg <= addr_in[ADDR_W-1:BURST_W];
        end
    end

    // Write controls and data are taken on every edge, used only in write cycles.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            lanes_reg <= LANES_NONE;
            wdata_reg <= DATA_RESET;
        end else begin
            lanes_reg <= lanes_next;
            wdata_reg <= dq_in;
        end
    end

    // The strap is static; it is read once on the first edge after reset release.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            linear_mode_reg <= LINEAR_RESET;
            strap_taken_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            linear_mode_reg <= (burst_order_strap == STRAP_LINEAR);
            strap_taken_reg <= 1'b1;
        end
    end

    // =========================================================
    // Burst counter and array
    // =========================================================
    sdcd_burst_ctr u_burst (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .load(addr_load),
        .load_bits(addr_in[BURST_W-1:0]),
        .step(burst_step),
        .linear_mode(linear_mode_reg),
        .burst_low(burst_low)
    );

    assign cur_addr = {addr_hi_reg, burst_low};

    // The array acts one edge after capture with no outside timing; sleep holds it still.
    assign wr_en = (state_reg == ST_WRITE) && !sleep_request;
    assign rd_en = (state_reg == ST_READ) && !sleep_request;
    assign wr_req = '{lanes: lanes_reg, addr: cur_addr, data: wdata_reg};

    sdcd_mem_array u_array (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .wr_en(wr_en),
        .wr_req(wr_req),
        .rd_en(rd_en),
        .rd_addr(cur_addr),
        .rd_data(rd_data)
    );

    // =========================================================
    // Output pipeline and drivers
    // =========================================================

    // Fresh data flag, plus the extra enable stage that outlives a deselect.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            read_out_reg <= 1'b0;
            dcd_hold_reg <= 1'b0;
        end else begin
            read_out_reg <= rd_en;
            dcd_hold_reg <= read_out_reg && (state_reg == ST_DESEL);
        end
    end

    // Drivers follow the output enable pin without a clock; the first clock of a read
    // has no fresh data yet, so the pin is masked there, which saves a bus turnaround.
    assign dq_oe = (read_out_reg || dcd_hold_reg) && !out_enable_n && !sleep_request;
    assign dq_out = rd_data;
    assign selected = (state_reg != ST_DESEL);

    // =========================================================
    // Checks
    // =========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Upper address changes only after a recognised strobe with selection.
    AST_ADDR_LOAD_GATED: assert property (
        $changed(addr_hi_reg) |-> $past((proc_seen || ctrl_seen) && sel_ok && !sleep_request))
        else $error("Address loaded without strobe and selection.");

    // A start with a missing select leaves the part deselected.
    AST_DESELECT_ON_BAD_SEL: assert property (
        ((proc_seen || ctrl_seen) && !sel_ok && !sleep_request) |=> (state_reg == ST_DESEL))
        else $error("Start without full selection was accepted.");

    // Processor strobe with first select high does nothing from idle.
    AST_PROC_IGNORED: assert property (
        (!ctl_pins.proc_addr_strobe_n && ctl_pins.chip_sel_a_n
            && ctl_pins.ctrl_addr_strobe_n && state_reg == ST_DESEL && !sleep_request)
        |=> (state_reg == ST_DESEL) && $stable(addr_hi_reg))
        else $error("Processor strobe acted while first select high.");

    // Both strobes with selection start a read even with writes asserted.
    AST_PROC_WINS: assert property (
        (!ctl_pins.proc_addr_strobe_n && !ctl_pins.ctrl_addr_strobe_n && sel_ok
            && lanes_next != LANES_NONE && !sleep_request) |=> (state_reg == ST_READ))
        else $error("Controller strobe won over processor strobe.");

    // Global write from a controller start stores all lanes.
    AST_GLOBAL_WRITE: assert property (
        (ctrl_seen && sel_ok && !ctl_pins.all_lanes_write_n && !sleep_request)
        |=> (state_reg == ST_WRITE) && (lanes_reg == LANES_ALL) ##1 read_out_reg == 1'b0)
        else $error("Global write did not write all lanes.");

    // Lane selects without the lane enable give a read.
    AST_LANE_ENABLE_QUAL: assert property (
        (ctrl_seen && sel_ok && ctl_pins.all_lanes_write_n && ctl_pins.lane_write_enable_n
            && !sleep_request) |=> (state_reg == ST_READ))
        else $error("Lane selects acted without lane enable.");

    // Advance low in a burst moves the beat address.
    AST_BURST_STEPS: assert property (
        (state_reg != ST_DESEL && !proc_seen && !ctrl_seen && !ctl_pins.burst_step_n
            && !sleep_request) |=> (burst_low != $past(burst_low)))
        else $error("Burst counter did not step on advance.");

    // Advance high suspends on the same address.
    AST_BURST_HOLDS: assert property (
        (state_reg != ST_DESEL && !proc_seen && !ctrl_seen && ctl_pins.burst_step_n)
        |=> $stable(cur_addr))
        else $error("Burst address moved without advance.");

    // Linear order adds one beat modulo four.
    AST_LINEAR_ORDER: assert property (
        (linear_mode_reg && burst_step) |=> (burst_low == BURST_W'($past(burst_low) + BEAT_ONE)))
        else $error("Linear burst did not add one.");

    // A read cycle yields fresh data on the next edge, driven while enabled.
    // The flag itself is required, so a lost read cannot slip through as vacuous.
    AST_READ_LATENCY: assert property (
        (state_reg == ST_READ && !sleep_request)
        |=> read_out_reg && (out_enable_n || sleep_request || dq_oe))
        else $error("Read data not presented one edge after capture.");

    // Once the first word is out, every stepped beat delivers a new word each cycle.
    // This is the single-cycle part of the burst rhythm; only the first word pays
    // for the input and output register stages.
    AST_BEAT_EACH_CYCLE: assert property (
        (rd_en && burst_step) |=> (read_out_reg && burst_low != $past(burst_low)))
        else $error("Burst beat did not deliver a word in one cycle.");

    // A write cycle with no read word or deselect hold pending keeps the data drivers off, so the master keeps the pins.
    AST_WRITE_NO_DRIVE: assert property (
        (state_reg == ST_WRITE && !read_out_reg && !dcd_hold_reg) |-> !dq_oe)
        else $error("Drivers on during a write cycle.");

    // A load always restarts the beat count, whatever the order.
    AST_LOAD_RESTARTS: assert property (
        addr_load |=> (burst_low == $past(addr_in[BURST_W-1:0])))
        else $error("Burst did not restart from the loaded low bits.");

    // Drivers stay on for one cycle after a deselect, then drop.
    AST_DCD_HOLD: assert property (
        (read_out_reg && state_reg == ST_DESEL && !sleep_request)
        |=> dcd_hold_reg ##1 (!dcd_hold_reg && !read_out_reg))
        else $error("Output drive not held one cycle after deselect.");

    // Output enable high or sleep high turns the drivers off at once.
    AST_ASYNC_OFF: assert property (
        (out_enable_n || sleep_request) |-> !dq_oe)
        else $error("Drivers on while output enable or sleep blocks them.");

    // No write reaches the array while asleep.
    AST_SLEEP_NO_WRITE: assert property (
        sleep_request |=> (state_reg == ST_DESEL) && !read_out_reg)
        else $error("Activity continued during sleep.");

    COV_PROC_READ: cover property (proc_seen && sel_ok ##1 state_reg == ST_READ ##1 dq_oe);
    COV_CTRL_WRITE: cover property (ctrl_seen && sel_ok ##1 state_reg == ST_WRITE);
    COV_BURST_FOUR: cover property (addr_load ##1 burst_step ##1 burst_step ##1 burst_step);
    COV_DCD: cover property (read_out_reg && state_reg == ST_DESEL ##1 dcd_hold_reg && dq_oe);

endmodule

//--- sdcd_port_test.sv
// Self-checking bench of the pipelined synchronous memory port.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module sdcd_port_test
    import sdcd_pkg::*;
;
    // =========================================================
    // Pin codes, fields as in sdcd_ctl_type
    // =========================================================
    localparam logic [11:0] IDLE = 12'hEBF; // Strobes high, selected, no write.
    localparam logic [11:0] RDP = 12'h6BF;  // Processor strobe read start.
    localparam logic [11:0] STEP = 12'hCBF; // Continue with advance low.
    localparam logic [11:0] WRG = 12'hA9F;  // Controller strobe, global write.
    localparam logic [11:0] DESEL = 12'hA3F; // Controller strobe, second enable low.
    logic ref_clk = 0;
    logic reset_n = 0;
    logic [ADDR_W-1:0] addr_in = '0;
    sdcd_ctl_type ctl = IDLE;
    logic [DATA_W-1:0] dq_in, dq_out, m_data = '0;
    logic dq_oe, selected, m_drive = 0;
    logic out_enable_n = 0;
    logic sleep_request = 0;
    logic strap = 1;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [DATA_W-1:0] mem [4]; // Expected words at the top four addresses.
    always #2.5 ref_clk = ~ref_clk;
    sdcd_port u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .addr_in(addr_in),
        .ctl_pins(ctl), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .out_enable_n(out_enable_n), .sleep_request(sleep_request),
        .burst_order_strap(strap), .selected(selected));
    sdcd_bus_model u_bus (.ref_clk(ref_clk), .dq_out(dq_out), .dq_oe(dq_oe),
        .m_drive(m_drive), .m_data(m_data), .dq_wire(dq_in));
    // Cut a hang short; the whole run needs well under this many cycles.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            finish_test();
        end
    end
    // Present one pin set just after an edge; it is sampled at the next edge.
    task automatic go(input logic [11:0] c, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        ctl <= c;
        addr_in <= a;
        m_data <= d;
        m_drive <= (c[5:4] != 2'h3);
    endtask
    // Reset for 20 cycles with a chosen burst order strap.
    task automatic do_reset(input logic s);
        reset_n <= 0;
        strap <= s;
        repeat (20) go(IDLE, 17'h0_0000, 32'h0000_0000);
        reset_n <= 1;
        go(IDLE, 17'h0_0000, 32'h0000_0000);
    endtask
    // Any write-like cycle, then two deselect cycles.
    task automatic wr(input logic [11:0] c, input logic [1:0] a, input logic [DATA_W-1:0] d);
        go(c, {15'h7FFF, a}, d);
        go(DESEL, 17'h0_0000, 32'h0000_0000);
        go(DESEL, 17'h0_0000, 32'h0000_0000);
    endtask
    // Single read: data and drive appear one edge after capture.
    task automatic rd(input logic [1:0] a);
        go(RDP, {15'h7FFF, a}, 32'h0000_0000);
        go(IDLE, 17'h0_0000, 32'h0000_0000);
        #1;
        `CHK(selected, 1'b1)
        @(posedge ref_clk);
        #1;
        `CHK(dq_out, mem[a])
        `CHK(dq_oe, 1'b1)
        go(DESEL, 17'h0_0000, 32'h0000_0000);
        go(DESEL, 17'h0_0000, 32'h0000_0000);
    endtask
    // Four-beat burst from base 1, then the extra drive cycle after deselect.
    task automatic burst(input logic lin);
        go(RDP, 17'h1_FFFD, 32'h0000_0000);
        go(STEP, 17'h0_0000, 32'h0000_0000);
        for (int n = 0; n < 4; n++) begin
            @(posedge ref_clk);
            #1;
            `CHK(dq_out, mem[lin ? 2'(1 + n) : 2'(1 ^ n)])
        end
        go(DESEL, 17'h0_0000, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK(dq_oe, 1'b1)
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK(dq_oe, 1'b0)
        $display("test burst order %0d done", lin);
    endtask
    // Refused starts and strobe priority leave the array untouched.
    task automatic refusals();
        go(12'h7BF, 17'h1_FFFC, 32'h0000_0000);
        go(DESEL, 17'h0_0000, 32'h0000_0000);
        #1;
        `CHK(selected, 1'b0)
        wr(12'hADF, 2'h0, 32'hDEAD_0001);
        wr(12'h29F, 2'h0, 32'hDEAD_0002);
        wr(12'hAB0, 2'h0, 32'hDEAD_0003);
        rd(2'h0);
        $display("test refusals done");
    endtask
    // Output enable and sleep act within the cycle, and sleep keeps data.
    task automatic async_pins();
        go(RDP, 17'h1_FFFE, 32'h0000_0000);
        repeat (2) go(IDLE, 17'h0_0000, 32'h0000_0000);
        out_enable_n <= 1;
        #1;
        `CHK(dq_oe, 1'b0)
        out_enable_n <= 0;
        #1;
        `CHK(dq_oe, 1'b1)
        sleep_request <= 1;
        #1;
        `CHK(dq_oe, 1'b0)
        go(DESEL, 17'h0_0000, 32'h0000_0000);
        sleep_request <= 0;
        repeat (3) go(DESEL, 17'h0_0000, 32'h0000_0000);
        rd(2'h2);
        $display("test async pins done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence: fill the top words, then run each scenario.
    initial begin
        do_reset(1'b1);
        for (int i = 0; i < 4; i++) begin
            mem[i] = 32'hA5C3_0000 | 32'(i * 32'h0101_0101);
            wr(WRG, 2'(i), mem[i]);
        end
        wr(12'hAAE, 2'h3, 32'h1234_5678);
        mem[3][7:0] = 8'h78;
        rd(2'h3);
        burst(1'b0);
        refusals();
        async_pins();
        do_reset(1'b0);
        burst(1'b1);
        finish_test();
    end
endmodule
